// file: cmw_consts.svh
// Constants for the message list walker: descriptor fields, offsets, timing.
// Assumes a 32-bit shared memory with byte addresses and dword descriptors.
`ifndef CMW_CONSTS_SVH
`define CMW_CONSTS_SVH

// Buffer control word fields
`define CMW_OWNER_BIT 31
`define CMW_NP_BIT 30
`define CMW_END_OF_BUFFER_IRQ_ENABLE_BIT 28
`define CMW_IC_BIT 27
`define CMW_BUFFER_LENGTH_FIELD_MSB 13
`define CMW_BUFFER_LENGTH_FIELD_W 14

// Byte offsets inside one list element and dword step
`define CMW_DPTR_OFS 32'h0000_0004
`define CMW_LINK_OFS 32'h0000_0008
`define CMW_WORD_STEP 32'h0000_0004
`define CMW_WORD_BYTES 15'h0004

// Status word: bytes moved in the low half
`define CMW_STAT_CNT_MSB 15

// Idle patterns between messages
`define CMW_IDLE_FLAG 8'h7E
`define CMW_IDLE_MARK 8'hFF

// Poll interval for a host-owned element
`define CMW_CLK_PERIOD_NS 5
`define CMW_POLL_NS 1000
`define CMW_POLL_CYCLES (`CMW_POLL_NS / `CMW_CLK_PERIOD_NS)

`endif

// file: cmw_pkg.sv
// Types shared by the message list walker.
// Assumes cmw_consts.svh is on the include path.
package cmw_pkg;

  // One-hot walker states
  typedef enum logic [9:0] {
    CMW_IDLE = 10'h001,
    CMW_HEAD = 10'h002,
    CMW_DESC = 10'h004,
    CMW_SLOT = 10'h008,
    CMW_XMEM = 10'h010,
    CMW_XSTR = 10'h020,
    CMW_LINK = 10'h040,
    CMW_STAT = 10'h080,
    CMW_POLL = 10'h100,
    CMW_PARK = 10'h200
  } cmw_state_type;

  // Bus master request towards shared memory
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cmw_mem_req_type;

endpackage

// file: cmw_walker.sv
// One channel direction walking a linked list of elements in shared memory.
// Assumes a memory port that holds ack high one cycle with read data, and
// stream ports on the same clock towards the serial side FIFO logic.
`timescale 1ns/100ps
`default_nettype none
`include "cmw_consts.svh"

// Functional notes
// - Element is three dwords: control word, buffer address, link address.
// - Test ownership first; after servicing, invert ownership bit back to host.
// - Host-owned element ends list; channel stays active, polls or idles.
// - No-poll bit 0 means re-poll a host-owned element periodically.
// - Transmit: owner 1 is device; load buffer address and length.
// - Receive: owner 0 is device, owner 1 is host.
// - Transmit activation reads head pointer, then the element it addresses.
// - Receive activation reads head pointer, then the element it addresses.
// - Inhibit 0: slot gets control word address; rereads link, writes status.
// - Inhibit 1: slot gets prefetched link; jump there without status overwrite.
// - Transmit: master reads buffer data into the transmit stream.
// - Receive: master writes received stream data into the buffer.
// - End of message: status word and end-of-buffer event, then fetch next element.
// - Each direction has own request; every request is acknowledged.
// - Idle select 0 gives 7Eh idle; length field is bytes.
module cmw_walker
  import cmw_pkg::*;
#(
  parameter bit IS_RX = 1'b0,
  parameter int POLL_CYCLES = `CMW_POLL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic srv_req,
  input wire logic srv_jump,
  input wire logic [31:0] head_ptr_addr,
  input wire logic [31:0] msg_slot_addr,
  input wire logic status_overwrite_inhibit,
  output cmw_mem_req_type mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  input wire logic [31:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic service_acknowledge_event,
  output logic end_of_buffer_event,
  output logic chan_active,
  output logic list_ended,
  output logic idle_code_select,
  output logic [7:0] idle_pattern
);

  localparam logic [31:0] OWNER_MASK = 32'h1 << `CMW_OWNER_BIT;
  localparam logic [15:0] POLL_LOAD = 16'(POLL_CYCLES - 1);

  cmw_state_type state, next_state;
  cmw_mem_req_type next_mem;
  logic [1:0] widx, next_widx;
  logic [31:0] desc_addr, next_desc_addr;
  logic [31:0] ctl, next_ctl;
  logic [31:0] link, next_link;
  logic [31:0] xaddr, next_xaddr;
  logic [14:0] remain, next_remain;
  logic [15:0] moved, next_moved;
  logic [15:0] poll_cnt, next_poll_cnt;
  logic pend_act, next_pend_act;
  logic pend_jmp, next_pend_jmp;
  logic [31:0] next_out_data;
  logic next_out_valid, next_in_ready, next_service_acknowledge_event, next_eob;
  logic next_active, next_ended, next_ic;
  logic [7:0] next_idle;
  logic owned, mem_free, last_word, end_msg;

  // Device owns the element when the ownership bit matches its direction
  assign owned = IS_RX ? ~ctl[`CMW_OWNER_BIT] : ctl[`CMW_OWNER_BIT];
  // No bus access left open after this cycle
  assign mem_free = ~mem.req | mem_ack;
  assign last_word = remain <= `CMW_WORD_BYTES;

  // Next state of the walker and its bus and stream outputs
  always_comb begin
    next_state = state;
    next_mem = mem;
    next_widx = widx;
    next_desc_addr = desc_addr;
    next_ctl = ctl;
    next_link = link;
    next_xaddr = xaddr;
    next_remain = remain;
    next_moved = moved;
    next_poll_cnt = poll_cnt;
    next_pend_act = pend_act;
    next_pend_jmp = pend_jmp;
    next_out_data = out_data;
    next_out_valid = out_valid;
    next_in_ready = in_ready;
    next_service_acknowledge_event = 1'b0;
    next_eob = 1'b0;
    next_active = chan_active;
    next_ended = list_ended;
    next_ic = idle_code_select;
    next_idle = idle_pattern;
    end_msg = 1'b0;
    if (mem_ack) begin
      next_mem.req = 1'b0;
    end
    // Requests are latched; a receive jump acts as an activation
    if (srv_req) begin
      if (srv_jump && !IS_RX) begin
        next_pend_jmp = 1'b1;
      end else begin
        next_pend_act = 1'b1;
      end
    end
    unique case (state)
      CMW_IDLE, CMW_PARK: begin
      end
      CMW_HEAD: begin
        if (mem_ack) begin
          // Head pointer kept, then the first element fetched
          next_desc_addr = mem_rdata;
          next_mem = '{1'b1, 1'b0, mem_rdata, 32'h0};
          next_widx = 2'h0;
          next_state = CMW_DESC;
        end
      end
      CMW_DESC: begin
        if (mem_ack) begin
          // Three consecutive dwords per element
          unique case (widx)
            2'h0: next_ctl = mem_rdata;
            2'h1: next_xaddr = mem_rdata;
            default: next_link = mem_rdata;
          endcase
          if (widx != 2'h2) begin
            next_widx = widx + 2'h1;
            next_mem = '{1'b1, 1'b0, mem.addr + `CMW_WORD_STEP, 32'h0};
          end else if (owned) begin
            // Load length; publish control address or prefetched link
            next_remain = {1'b0, ctl[`CMW_BUFFER_LENGTH_FIELD_MSB:0]};
            next_moved = 16'h0;
            next_ended = 1'b0;
            next_ic = ctl[`CMW_IC_BIT];
            next_idle = ctl[`CMW_IC_BIT] ? `CMW_IDLE_MARK : `CMW_IDLE_FLAG;
            next_mem = '{1'b1, 1'b1, msg_slot_addr,
                         status_overwrite_inhibit ? mem_rdata : desc_addr};
            next_state = CMW_SLOT;
          end else begin
            // Host-owned: list ends, channel stays active
            next_ended = 1'b1;
            if (ctl[`CMW_NP_BIT]) begin
              next_state = CMW_PARK;
            end else begin
              next_poll_cnt = POLL_LOAD;
              next_state = CMW_POLL;
            end
          end
        end
      end
      CMW_SLOT: begin
        if (mem_ack) begin
          if (remain == 15'h0) begin
            end_msg = 1'b1;
          end else if (!IS_RX) begin
            next_mem = '{1'b1, 1'b0, xaddr, 32'h0};
            next_state = CMW_XMEM;
          end else begin
            next_in_ready = 1'b1;
            next_state = CMW_XSTR;
          end
        end
      end
      CMW_XMEM: begin
        if (mem_ack) begin
          if (!IS_RX) begin
            // Buffer word goes out to the transmit stream
            next_out_data = mem_rdata;
            next_out_valid = 1'b1;
            next_state = CMW_XSTR;
          end else begin
            next_xaddr = xaddr + `CMW_WORD_STEP;
            next_remain = last_word ? 15'h0 : remain - `CMW_WORD_BYTES;
            next_moved = moved + (last_word ? {1'b0, remain} : 16'h4);
            if (last_word) begin
              end_msg = 1'b1;
            end else begin
              next_in_ready = 1'b1;
              next_state = CMW_XSTR;
            end
          end
        end
      end
      CMW_XSTR: begin
        if (!IS_RX && out_valid && out_ready) begin
          next_out_valid = 1'b0;
          next_xaddr = xaddr + `CMW_WORD_STEP;
          next_remain = last_word ? 15'h0 : remain - `CMW_WORD_BYTES;
          next_moved = moved + (last_word ? {1'b0, remain} : 16'h4);
          if (last_word) begin
            end_msg = 1'b1;
          end else begin
            next_mem = '{1'b1, 1'b0, xaddr + `CMW_WORD_STEP, 32'h0};
            next_state = CMW_XMEM;
          end
        end else if (IS_RX && in_valid && in_ready) begin
          // Received word written into the buffer
          next_in_ready = 1'b0;
          next_mem = '{1'b1, 1'b1, xaddr, in_data};
          next_state = CMW_XMEM;
        end
      end
      CMW_LINK: begin
        if (mem_ack) begin
          // Link reread, then the control word becomes a status word
          next_link = mem_rdata;
          next_mem = '{1'b1, 1'b1, desc_addr,
                       {~ctl[`CMW_OWNER_BIT], 15'h0, moved}};
          next_state = CMW_STAT;
        end
      end
      CMW_STAT: begin
        if (mem_ack) begin
          next_eob = ctl[`CMW_END_OF_BUFFER_IRQ_ENABLE_BIT];
          if (pend_jmp) begin
            next_pend_jmp = 1'b0;
            next_service_acknowledge_event = 1'b1;
            next_mem = '{1'b1, 1'b0, head_ptr_addr, 32'h0};
            next_state = CMW_HEAD;
          end else begin
            // Follow the link to the next element
            next_desc_addr = link;
            next_mem = '{1'b1, 1'b0, link, 32'h0};
            next_widx = 2'h0;
            next_state = CMW_DESC;
          end
        end
      end
      CMW_POLL: begin
        if (poll_cnt == 16'h0) begin
          // Re-read the same element to see whether ownership changed
          next_mem = '{1'b1, 1'b0, desc_addr, 32'h0};
          next_widx = 2'h0;
          next_state = CMW_DESC;
        end else begin
          next_poll_cnt = poll_cnt - 16'h1;
        end
      end
    endcase
    // Message finished: status or ownership return
    if (end_msg) begin
      if (!status_overwrite_inhibit) begin
        next_mem = '{1'b1, 1'b0, desc_addr + `CMW_LINK_OFS, 32'h0};
        next_state = CMW_LINK;
      end else begin
        next_mem = '{1'b1, 1'b1, desc_addr, ctl ^ OWNER_MASK};
        next_state = CMW_STAT;
      end
    end
    // Activation restarts once no bus access is open; a jump too, but only when idle, parked or polling
    if (mem_free && (next_pend_act ||
        (next_pend_jmp && (state == CMW_IDLE || state == CMW_PARK || state == CMW_POLL)))) begin
      next_pend_act = 1'b0;
      next_pend_jmp = 1'b0;
      next_service_acknowledge_event = 1'b1;
      next_active = 1'b1;
      next_out_valid = 1'b0;
      next_in_ready = 1'b0;
      next_mem = '{1'b1, 1'b0, head_ptr_addr, 32'h0};
      next_state = CMW_HEAD;
    end
  end

  // Register all walker state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= CMW_IDLE;
      mem <= '0;
      widx <= 2'h0;
      desc_addr <= 32'h0;
      ctl <= 32'h0;
      link <= 32'h0;
      xaddr <= 32'h0;
      remain <= 15'h0;
      moved <= 16'h0;
      poll_cnt <= 16'h0;
      pend_act <= 1'b0;
      pend_jmp <= 1'b0;
      out_data <= 32'h0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
      service_acknowledge_event <= 1'b0;
      end_of_buffer_event <= 1'b0;
      chan_active <= 1'b0;
      list_ended <= 1'b0;
      idle_code_select <= 1'b0;
      idle_pattern <= `CMW_IDLE_FLAG;
    end else begin
      state <= next_state;
      mem <= next_mem;
      widx <= next_widx;
      desc_addr <= next_desc_addr;
      ctl <= next_ctl;
      link <= next_link;
      xaddr <= next_xaddr;
      remain <= next_remain;
      moved <= next_moved;
      poll_cnt <= next_poll_cnt;
      pend_act <= next_pend_act;
      pend_jmp <= next_pend_jmp;
      out_data <= next_out_data;
      out_valid <= next_out_valid;
      in_ready <= next_in_ready;
      service_acknowledge_event <= next_service_acknowledge_event;
      end_of_buffer_event <= next_eob;
      chan_active <= next_active;
      list_ended <= next_ended;
      idle_code_select <= next_ic;
      idle_pattern <= next_idle;
    end
  end

endmodule
`default_nettype wire

// file: cmw_walker_sva.sv
// Checker for the list walker: bus holding, acknowledge, events, idle pattern.
// Assumes it is bound to every cmw_walker instance.
`timescale 1ns/100ps
`default_nettype none
module cmw_walker_sva
  import cmw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic srv_req,
  input wire logic [31:0] head_ptr_addr,
  input wire cmw_mem_req_type mem,
  input wire logic mem_ack,
  input wire logic [31:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic service_acknowledge_event,
  input wire logic end_of_buffer_event,
  input wire logic chan_active,
  input wire logic idle_code_select,
  input wire logic [7:0] idle_pattern
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Steps of an activation
  sequence s_req; srv_req; endsequence
  sequence s_head; mem.req && !mem.we && mem.addr == head_ptr_addr; endsequence
  property p_req_hold; mem.req && !mem_ack |=> mem.req && $stable(mem); endproperty
  property p_service_acknowledge_event; s_req |-> ##[1:100] service_acknowledge_event; endproperty
  property p_service_acknowledge_event_head; service_acknowledge_event |-> ##[0:1] s_head; endproperty
  property p_service_acknowledge_event_once; service_acknowledge_event |=> !service_acknowledge_event; endproperty
  property p_eob_once; end_of_buffer_event |=> !end_of_buffer_event; endproperty
  property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  property p_active; chan_active |=> chan_active; endproperty
  property p_idle;
    $stable(idle_code_select) |-> idle_pattern == (idle_code_select ? 8'hFF : 8'h7E);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request moved");
  a_service_acknowledge_event: assert property (p_service_acknowledge_event) else $error("no acknowledge");
  a_service_acknowledge_event_head: assert property (p_service_acknowledge_event_head) else $error("head not read");
  a_service_acknowledge_event_once: assert property (p_service_acknowledge_event_once) else $error("long acknowledge");
  a_eob_once: assert property (p_eob_once) else $error("long end event");
  a_out_hold: assert property (p_out_hold) else $error("stream word moved");
  a_active: assert property (p_active) else $error("channel dropped");
  a_idle: assert property (p_idle) else $error("idle pattern wrong");
endmodule
bind cmw_walker cmw_walker_sva u_sva (.sys_clk, .nrst, .srv_req, .head_ptr_addr, .mem,
  .mem_ack, .out_data, .out_valid, .out_ready, .service_acknowledge_event,
  .end_of_buffer_event, .chan_active, .idle_code_select, .idle_pattern);
`default_nettype wire

// file: cmw_mem_model.sv
// Shared memory model answering the walker's bus master port.
// Assumes the bench sets the answer delay and writes the host's lists.
`timescale 1ns/100ps
`default_nettype none
module cmw_mem_model
  import cmw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cmw_mem_req_type mem,
  input wire logic [1:0] dly,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] words [0:255]; // Elements of three dwords
  logic [1:0] cnt;
  initial mem_rdata = 32'h0;
  // Answer after dly waits; read data toggles unless answering a read
  always @(posedge sys_clk) begin
    mem_ack <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (!nrst) begin
      cnt <= 2'h0;
    end else if (mem.req && !mem_ack) begin
      if (cnt >= dly) begin
        mem_ack <= 1'h1;
        cnt <= 2'h0;
        if (mem.we) words[mem.addr[9:2]] <= mem.wdata;
        else mem_rdata <= words[mem.addr[9:2]];
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Testbench: transmit walker against the shared memory model.
// Assumes random stalls on memory and stream; lists set up by the bench.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cmw_pkg::*;
  logic sys_clk, nrst, srv_req, status_overwrite_inhibit, mem_ack, out_valid, out_ready;
  logic service_acknowledge_event, end_of_buffer_event, chan_active, list_ended;
  logic idle_code_select, ic0, ic1, poll, srv_jump;
  logic [31:0] head_ptr;
  logic [31:0] mem_rdata, out_data, ctrl0, ctrl1, len;
  logic [7:0] idle_pattern;
  logic [1:0] dly;
  cmw_mem_req_type mem;
  int seed = 80869;
  int mismatches = 0;
  int n_tests = 0;
  int eobs = 0;
  logic [31:0] got [$];
  cmw_walker #(.IS_RX(1'h0), .POLL_CYCLES(4)) DUT (.*, .head_ptr_addr(head_ptr),
    .msg_slot_addr(32'h4), .in_data(32'h0), .in_valid(1'h0), .in_ready());
  cmw_mem_model MEM (.sys_clk, .nrst, .mem, .dly, .mem_ack, .mem_rdata);
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Random stalls; collect stream words and end events
  always @(posedge sys_clk) begin
    if (nrst && out_valid && out_ready) got.push_back(out_data);
    if (nrst && end_of_buffer_event) eobs++;
    out_ready <= #1 $random(seed);
    dly <= #1 $random(seed);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Wait until the given messages are done and the list has ended
  task automatic wait_idle(input int want);
    int i;
    for (i = 0; i < 3000; i++) begin
      if (eobs >= want && list_ended === 1'h1 && mem.req === 1'h0) break;
      tick(1);
    end
    if (i == 3000) begin
      mismatches++;
      finish_test;
    end
  endtask
  // Control word left behind after a message
  function automatic logic [31:0] exp_ctrl(input logic [31:0] c, input logic i,
    input logic [31:0] n);
    return i ? c ^ 32'h8000_0000 : {16'h0, n[15:0]};
  endfunction
  initial begin
    nrst = 1'h0;
    srv_req = 1'h0;
    srv_jump = 1'h0;
    head_ptr = 32'h0;
    status_overwrite_inhibit = 1'h0;
    out_ready = 1'h0;
    dly = 2'h0;
    tick(4);
    nrst = 1'h1;
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        nrst = 1'h0;
        tick(4);
        check(32'(chan_active), 32'h0);
        check(32'(mem.req), 32'h0);
        nrst = 1'h1;
      end
      status_overwrite_inhibit = k[0];
      poll = k[1];
      ic0 = $random(seed);
      ic1 = $random(seed);
      len = (k == 0) ? 32'h1 : 32'(($random(seed) & 15) + 1);
      ctrl0 = {4'h9, ic0, 13'h0, len[13:0]};
      ctrl1 = {1'h0, !poll, 2'h1, ic1, 13'h0, 14'h4};
      // Head pointer, owned element, host-owned self-linked last element
      MEM.words[0] = 32'h40;
      MEM.words[16] = ctrl0;
      MEM.words[17] = 32'h100;
      MEM.words[18] = 32'h50;
      MEM.words[20] = ctrl1;
      MEM.words[21] = 32'h140;
      MEM.words[22] = 32'h50;
      for (int i = 0; i < 5; i++) MEM.words[64 + i] = $random(seed);
      MEM.words[80] = $random(seed);
      got.delete();
      eobs = 0;
      srv_req = 1'h1;
      tick(1);
      srv_req = 1'h0;
      wait_idle(1);
      check(32'(got.size()), (len + 3) / 4);
      for (int i = 0; i < got.size(); i++) check(got[i], MEM.words[64 + i]);
      check(MEM.words[1], status_overwrite_inhibit ? 32'h50 : 32'h40);
      check(MEM.words[16], exp_ctrl(ctrl0, status_overwrite_inhibit, len));
      check(32'(list_ended), 32'h1);
      // Idle select follows the last element the walker owned
      check(32'(idle_pattern), ic0 ? 32'hFF : 32'h7E);
      check(32'(eobs), 32'h1);
      // Host hands the last element over while the walker waits
      MEM.words[20] = ctrl1 ^ 32'h8000_0000;
      if (poll) begin
        wait_idle(2);
        check(got[got.size() - 1], MEM.words[80]);
        check(MEM.words[20], exp_ctrl(ctrl1 ^ 32'h8000_0000, k[0], 32'h4));
      end else begin
        tick(40);
        check(32'(eobs), 32'h1);
        // Jump while parked rereads the head; that element is host-owned now
        srv_jump = 1'h1;
        srv_req = 1'h1;
        tick(1);
        srv_req = 1'h0;
        srv_jump = 1'h0;
        tick(40);
        check(32'(list_ended), 32'h1);
        check(32'(eobs), 32'h1);
      end
    end
    finish_test;
  end
endmodule
`default_nettype wire
